/* File: shared/pio_pkg.sv */
// constants for the four parallel i/o ports
package pio_pkg;

  // =====================================================
  // register offsets
  localparam logic [7:0] NIBBLE_PORT_OFS = 8'h00;
  localparam logic [7:0] BYTE_PORT_OFS = 8'h01;
  localparam logic [7:0] BITWISE_PORT_OFS = 8'h02;
  localparam logic [7:0] FIXED_PORT_OFS = 8'h03;
  localparam logic [7:0] BITWISE_DIR_OFS = 8'hf6;
  localparam logic [7:0] FIXED_FUNC_OFS = 8'hf7;
  localparam logic [7:0] NIBBLE_BYTE_MODE_OFS = 8'hf8;

  // =====================================================
  // values after reset
  localparam logic [7:0] NIBBLE_BYTE_MODE_RST = 8'h49;
  localparam logic [7:0] BITWISE_DIR_RST = 8'hff;
  localparam logic [7:0] FIXED_FUNC_RST = 8'h00;
  localparam logic [7:0] PORT_DATA_RST = 8'h00;
  localparam logic [3:0] FIXED_OUT_RST = 4'hf;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // =====================================================
  // field positions and codes
  localparam int NIB_LO_POS = 0;
  localparam int BYTE_DIR_POS = 3;
  localparam int NIB_HI_POS = 6;
  localparam logic [1:0] DIR_OUTPUT = 2'h0;
  localparam logic [1:0] DIR_INPUT = 2'h1;
  localparam int FUNC_OPEN_DRAIN_POS = 0;
  localparam int FUNC_NIB_HS_POS = 2;
  localparam int FUNC_BYTE_HS_LO_POS = 3;
  localparam int FUNC_BYTE_HS_HI_POS = 4;
  localparam int FUNC_BIT_HS_POS = 6;

  // =====================================================
  // sizes and timing
  localparam int PORT_W = 8;
  localparam int FIXED_IN_W = 4;
  localparam int SYNC_W = 3 * PORT_W + FIXED_IN_W;
  localparam int RSP_DEPTH = 2;

endpackage

/* File: rtl/pio_buffer.sv */
// two-entry valid/ready buffer for read answers
`timescale 1ns/10ps
module pio_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

/* File: rtl/pio_handshake.sv */
// interlocked strobe/ack engine for one port
`timescale 1ns/10ps
module pio_handshake (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic dir_in,
  input wire logic line_in,
  input wire logic rd_pulse,
  input wire logic wr_pulse,
  output logic line_out,
  output logic capture,
  output logic held
);
  logic held_reg;
  logic ack_reg;
  logic busy_reg;

  // capture only while ack is high, so a lingering low strobe never recaptures
  assign capture = enable & dir_in & ~held_reg & ack_reg & ~line_in;
  assign held = held_reg;
  assign line_out = dir_in ? ack_reg : ~busy_reg;

  // =====================================================
  // input side: capture, lock, ack
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      held_reg <= 1'b0;
    end else if (!(enable && dir_in)) begin
      held_reg <= 1'b0;
    end else if (capture) begin
      held_reg <= 1'b1;
    end else if (rd_pulse) begin
      held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_reg <= 1'b1;
    end else if (!(enable && dir_in)) begin
      ack_reg <= 1'b1;
    end else if (capture) begin
      ack_reg <= 1'b0;
    end else if (!held_reg && line_in) begin
      ack_reg <= 1'b1;
    end
  end

  // =====================================================
  // output side: strobe low on write while ack high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_reg <= 1'b0;
    end else if (!enable || dir_in) begin
      busy_reg <= 1'b0;
    end else if (!busy_reg && wr_pulse && line_in) begin
      busy_reg <= 1'b1;
    end else if (busy_reg && !line_in) begin
      busy_reg <= 1'b0;
    end
  end
endmodule

/* File: rtl/pio_top.sv */
// four parallel i/o ports with register access and handshakes
//
// Behaviour
// - nibble port data at 00h only while extended bank select is 0
// - reading port bits returns the synchronised pin level
// - handshake input bits read the strobe-captured value
// - mode bits 1:0 set lower nibble direction, 01 in, 00 out
// - mode bits 7:6 set upper nibble direction, 01 in, 00 out
// - function bit 2 enables nibble handshake on fixed bits 2 and 5
// - nibble handshake direction follows upper half; lower joins when equal
// - byte port data at 01h; writes store output register
// - mode bits 4:3 set byte direction, 00 out, 01 in
// - function bits 4,3 both set enable byte handshake on bits 3 and 4
// - byte handshake direction follows byte port direction
// - bitwise direction bit 1 means input, 0 means output
// - bitwise data at 02h drives all output-configured bits
// - one global push-pull or open-drain choice for bitwise outputs
// - with serial enabled, bitwise bit 0 is data in, bit 7 data out
// - function bit 6 selects bitwise handshake else timer input
// - bitwise handshake follows bit 7 direction; matching bits take part
// - fixed port has four inputs, four outputs, one register each
// - pin inputs pass two flip-flops before any read
// - first strobe captures; later strobes ignored until port read
// - ack low after capture, high after read with strobe high
// - write lowers strobe only if ack high; strobe rises on ack low
`timescale 1ns/10ps
module pio_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic extended_register_bank,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [7:0] rsp_rdata,
  input wire logic [pio_pkg::PORT_W-1:0] nibble_pin_in,
  output logic [pio_pkg::PORT_W-1:0] nibble_pin_out,
  output logic [pio_pkg::PORT_W-1:0] nibble_pin_oe,
  input wire logic [pio_pkg::PORT_W-1:0] byte_pin_in,
  output logic [pio_pkg::PORT_W-1:0] byte_pin_out,
  output logic [pio_pkg::PORT_W-1:0] byte_pin_oe,
  input wire logic [pio_pkg::PORT_W-1:0] bitwise_pin_in,
  output logic [pio_pkg::PORT_W-1:0] bitwise_pin_out,
  output logic [pio_pkg::PORT_W-1:0] bitwise_pin_oe,
  input wire logic [pio_pkg::FIXED_IN_W-1:0] fixed_in,
  output logic [7:4] fixed_out,
  input wire logic spi_enable,
  input wire logic spi_data_out,
  output logic spi_data_in,
  output logic timer_input_line
);
  import pio_pkg::*;

  // =====================================================
  // input synchronisers
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [PORT_W-1:0] nib_sync;
  logic [PORT_W-1:0] byte_sync;
  logic [PORT_W-1:0] bit_sync;
  logic [FIXED_IN_W-1:0] fix_sync;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {fixed_in, bitwise_pin_in, byte_pin_in, nibble_pin_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign nib_sync = sync2_reg[PORT_W-1:0];
  assign byte_sync = sync2_reg[2*PORT_W-1:PORT_W];
  assign bit_sync = sync2_reg[3*PORT_W-1:2*PORT_W];
  assign fix_sync = sync2_reg[SYNC_W-1:3*PORT_W];

  // =====================================================
  // register access decode
  logic acc;
  logic wr;
  logic rd;
  logic hit_nib;
  logic hit_byte;
  logic hit_bit;
  logic hit_fix;
  logic hit_dir;
  logic hit_func;
  logic hit_mode;

  assign acc = req_valid & req_ready;
  assign wr = acc & req_write;
  assign rd = acc & ~req_write;
  assign hit_nib = (req_addr == NIBBLE_PORT_OFS) && !extended_register_bank;
  assign hit_byte = (req_addr == BYTE_PORT_OFS);
  assign hit_bit = (req_addr == BITWISE_PORT_OFS);
  assign hit_fix = (req_addr == FIXED_PORT_OFS);
  assign hit_dir = (req_addr == BITWISE_DIR_OFS);
  assign hit_func = (req_addr == FIXED_FUNC_OFS);
  assign hit_mode = (req_addr == NIBBLE_BYTE_MODE_OFS);

  // =====================================================
  // mode and direction registers
  logic [7:0] mode_reg;
  logic [7:0] dir_reg;
  logic [7:0] func_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= NIBBLE_BYTE_MODE_RST;
    end else if (wr && hit_mode) begin
      mode_reg <= req_wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dir_reg <= BITWISE_DIR_RST;
    end else if (wr && hit_dir) begin
      dir_reg <= req_wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      func_reg <= FIXED_FUNC_RST;
    end else if (wr && hit_func) begin
      func_reg <= req_wdata;
    end
  end

  // =====================================================
  // port output registers
  logic [PORT_W-1:0] nib_out_reg;
  logic [PORT_W-1:0] byte_out_reg;
  logic [PORT_W-1:0] bit_out_reg;
  logic [7:4] fix_out_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nib_out_reg <= PORT_DATA_RST;
    end else if (wr && hit_nib) begin
      nib_out_reg <= req_wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      byte_out_reg <= PORT_DATA_RST;
    end else if (wr && hit_byte) begin
      byte_out_reg <= req_wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_out_reg <= PORT_DATA_RST;
    end else if (wr && hit_bit) begin
      bit_out_reg <= req_wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fix_out_reg <= FIXED_OUT_RST;
    end else if (wr && hit_fix) begin
      fix_out_reg <= req_wdata[7:4];
    end
  end

  // =====================================================
  // direction decode
  logic nib_lo_out;
  logic nib_hi_out;
  logic nib_lo_in;
  logic nib_hi_in;
  logic byte_is_out;
  logic byte_is_in;
  logic open_drain;
  logic [PORT_W-1:0] nib_drive;
  logic [PORT_W-1:0] byte_drive;
  logic [PORT_W-1:0] bit_drive;

  assign nib_lo_out = (mode_reg[NIB_LO_POS+:2] == DIR_OUTPUT);
  assign nib_lo_in = (mode_reg[NIB_LO_POS+:2] == DIR_INPUT);
  assign nib_hi_out = (mode_reg[NIB_HI_POS+:2] == DIR_OUTPUT);
  assign nib_hi_in = (mode_reg[NIB_HI_POS+:2] == DIR_INPUT);
  assign byte_is_out = (mode_reg[BYTE_DIR_POS+:2] == DIR_OUTPUT);
  assign byte_is_in = (mode_reg[BYTE_DIR_POS+:2] == DIR_INPUT);
  assign open_drain = func_reg[FUNC_OPEN_DRAIN_POS];
  assign nib_drive = {{4{nib_hi_out}}, {4{nib_lo_out}}};
  assign byte_drive = {PORT_W{byte_is_out}};

  // serial overrides bit 0 to input and bit 7 to output
  always_comb begin
    bit_drive = ~dir_reg;
    if (spi_enable) begin
      bit_drive[0] = 1'b0;
      bit_drive[7] = 1'b1;
    end
  end

  // =====================================================
  // handshake engines
  logic nib_hs_en;
  logic byte_hs_en;
  logic bit_hs_en;
  logic nib_line;
  logic byte_line;
  logic bit_line;
  logic nib_cap;
  logic byte_cap;
  logic bit_cap;
  logic nib_held;
  logic byte_held;
  logic bit_held;

  assign nib_hs_en = func_reg[FUNC_NIB_HS_POS] && (nib_hi_in || nib_hi_out);
  assign byte_hs_en = func_reg[FUNC_BYTE_HS_HI_POS] && func_reg[FUNC_BYTE_HS_LO_POS]
    && (byte_is_in || byte_is_out);
  assign bit_hs_en = func_reg[FUNC_BIT_HS_POS];

  pio_handshake u_nib_hs (
    .clk(clk),
    .reset_n(reset_n),
    .enable(nib_hs_en),
    .dir_in(nib_hi_in),
    .line_in(fix_sync[2]),
    .rd_pulse(rd && hit_nib),
    .wr_pulse(wr && hit_nib),
    .line_out(nib_line),
    .capture(nib_cap),
    .held(nib_held)
  );

  pio_handshake u_byte_hs (
    .clk(clk),
    .reset_n(reset_n),
    .enable(byte_hs_en),
    .dir_in(byte_is_in),
    .line_in(fix_sync[3]),
    .rd_pulse(rd && hit_byte),
    .wr_pulse(wr && hit_byte),
    .line_out(byte_line),
    .capture(byte_cap),
    .held(byte_held)
  );

  pio_handshake u_bit_hs (
    .clk(clk),
    .reset_n(reset_n),
    .enable(bit_hs_en),
    .dir_in(dir_reg[7]),
    .line_in(fix_sync[1]),
    .rd_pulse(rd && hit_bit),
    .wr_pulse(wr && hit_bit),
    .line_out(bit_line),
    .capture(bit_cap),
    .held(bit_held)
  );

  // =====================================================
  // strobe-captured input registers
  logic [PORT_W-1:0] nib_cap_reg;
  logic [PORT_W-1:0] byte_cap_reg;
  logic [PORT_W-1:0] bit_cap_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nib_cap_reg <= PORT_DATA_RST;
      byte_cap_reg <= PORT_DATA_RST;
      bit_cap_reg <= PORT_DATA_RST;
    end else begin
      if (nib_cap) begin
        nib_cap_reg <= nib_sync;
      end
      if (byte_cap) begin
        byte_cap_reg <= byte_sync;
      end
      if (bit_cap) begin
        bit_cap_reg <= bit_sync;
      end
    end
  end

  // =====================================================
  // read data selection
  logic [PORT_W-1:0] nib_mask;
  logic [PORT_W-1:0] byte_mask;
  logic [PORT_W-1:0] bit_mask;
  logic [7:0] nib_rd;
  logic [7:0] byte_rd;
  logic [7:0] bit_rd;
  logic [7:0] rdata;

  // lower nibble joins only with matching direction
  assign nib_mask = {4'hf, {4{mode_reg[NIB_LO_POS+:2] == mode_reg[NIB_HI_POS+:2]}}}
    & {PORT_W{nib_hs_en & nib_hi_in}};
  assign byte_mask = {PORT_W{byte_hs_en & byte_is_in}};
  assign bit_mask = ~(dir_reg ^ {PORT_W{dir_reg[7]}}) & {PORT_W{bit_hs_en & dir_reg[7]}};
  assign nib_rd = (nib_mask & nib_cap_reg) | (~nib_mask & nib_sync);
  assign byte_rd = (byte_mask & byte_cap_reg) | (~byte_mask & byte_sync);
  assign bit_rd = (bit_mask & bit_cap_reg) | (~bit_mask & bit_sync);

  always_comb begin
    rdata = READ_ZERO;
    if (hit_nib) begin
      rdata = nib_rd;
    end else if (hit_byte) begin
      rdata = byte_rd;
    end else if (hit_bit) begin
      rdata = bit_rd;
    end else if (hit_fix) begin
      rdata = {fixed_out, fix_sync};
    end else if (hit_dir) begin
      rdata = dir_reg;
    end else if (hit_mode) begin
      rdata = mode_reg;
    end
  end

  pio_buffer #(
    .WIDTH(8),
    .DEPTH(RSP_DEPTH)
  ) u_rsp_buf (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(rd),
    .in_ready(req_ready),
    .in_data(rdata),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data(rsp_rdata)
  );

  // =====================================================
  // pin drivers
  assign nibble_pin_out = nib_out_reg;
  assign nibble_pin_oe = nib_drive;
  assign byte_pin_out = byte_out_reg;
  assign byte_pin_oe = byte_drive;

  always_comb begin
    bitwise_pin_out = bit_out_reg;
    if (spi_enable) begin
      bitwise_pin_out[7] = spi_data_out;
    end
    bitwise_pin_oe = bit_drive & (~{PORT_W{open_drain}} | ~bitwise_pin_out);
    if (open_drain) begin
      bitwise_pin_out = '0;
    end
  end

  assign spi_data_in = spi_enable & bit_sync[0];
  assign timer_input_line = ~bit_hs_en & fix_sync[1];

  // handshake lines take over their fixed outputs
  assign fixed_out[4] = byte_hs_en ? byte_line : fix_out_reg[4];
  assign fixed_out[5] = nib_hs_en ? nib_line : fix_out_reg[5];
  assign fixed_out[6] = bit_hs_en ? bit_line : fix_out_reg[6];
  assign fixed_out[7] = fix_out_reg[7];

endmodule

/* File: dv/pio_checker.sv */
// concurrent checks on the parallel port block register bus and pins
`timescale 1ns/10ps
module pio_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [7:0] rsp_rdata,
  input wire logic [7:0] nibble_pin_oe,
  input wire logic [7:0] byte_pin_oe,
  input wire logic [7:0] bitwise_pin_in,
  input wire logic [7:0] bitwise_pin_oe,
  input wire logic [3:0] fixed_in,
  input wire logic [7:4] fixed_out,
  input wire logic spi_enable,
  input wire logic spi_data_in,
  input wire logic timer_input_line
);
  logic take_rd;
  assign take_rd = req_valid && req_ready && !req_write && !rsp_valid;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ====
  // register bus
  AST_READY_FREE: assert property (!rsp_valid |-> req_ready)
    else $error("request refused while no answer waits");
  AST_READ_ANSWER: assert property (take_rd |=> rsp_valid)
    else $error("read answer missing");
  AST_ANSWER_HOLDS: assert property (
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_rdata))
    else $error("answer dropped before taken");
  AST_FUNC_READS_ZERO: assert property (
    take_rd && req_addr == 8'hf7 |=> rsp_rdata == 8'h00)
    else $error("write-only register read nonzero");
  // ====
  // pins
  AST_NIBBLE_WHOLE: assert property (
    nibble_pin_oe[3:0] inside {4'h0, 4'hf} && nibble_pin_oe[7:4] inside {4'h0, 4'hf})
    else $error("nibble drive split");
  AST_BYTE_WHOLE: assert property (byte_pin_oe inside {8'h00, 8'hff})
    else $error("byte drive split");
  AST_FIXED_OUT_SEVEN: assert property (
    req_valid && req_ready && req_write && req_addr == 8'h03
    |=> fixed_out[7] == $past(req_wdata[7]))
    else $error("fixed output bit seven not stored");
  AST_TIMER_SYNC: assert property (timer_input_line |-> $past(fixed_in[1], 2))
    else $error("timer line not two stages behind pin");
  AST_SPI_IN_SYNC: assert property (spi_data_in |-> $past(bitwise_pin_in[0], 2))
    else $error("serial input not two stages behind pin");
  AST_SPI_BIT0_IN: assert property (
    spi_enable && $past(spi_enable) |-> !bitwise_pin_oe[0])
    else $error("serial input pin driven");
endmodule
bind pio_top pio_checker chk (.clk, .reset_n, .req_valid, .req_ready, .req_write,
  .req_addr, .req_wdata, .rsp_valid, .rsp_ready, .rsp_rdata, .nibble_pin_oe,
  .byte_pin_oe, .bitwise_pin_in, .bitwise_pin_oe, .fixed_in, .fixed_out, .spi_enable,
  .spi_data_in, .timer_input_line);

/* File: dv/pio_peer.sv */
// handshake peripheral: sends on a strobe or receives and acknowledges
`timescale 1ns/10ps
module pio_peer #(
  parameter bit SEND = 1'b1,
  parameter int DLY = 2
) (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] word,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic [7:0] got,
  output logic line_out,
  input wire logic line_in
);
  int n;
  initial begin
    line_out = 1'b1;
    data_out = 8'h00;
    got = 8'h00;
    forever begin
      @(negedge clk);
      if (SEND && go) begin
        data_out = word;
        @(negedge clk);
        for (n = 0; n < 200 && !line_in; n++) @(negedge clk);
        line_out = 1'b0;
        for (n = 0; n < 200 && line_in; n++) @(negedge clk);
        repeat (DLY) @(negedge clk);
        line_out = 1'b1;
        data_out = ~word;
      end else if (!SEND && line_in === 1'b0) begin
        got = data_in;
        repeat (DLY) @(negedge clk);
        line_out = 1'b0;
        for (n = 0; n < 200 && !line_in; n++) @(negedge clk);
        line_out = 1'b1;
      end
    end
  end
endmodule

/* File: dv/pio_top_tb.sv */
// self-checking bench for the parallel port block
`timescale 1ns/10ps
module pio_top_tb;
  import pio_pkg::*;
  logic clk, reset_n, extended_register_bank, req_valid, req_ready, req_write, rsp_valid;
  logic rsp_ready, spi_enable, spi_data_out, spi_data_in, timer_input_line;
  logic [7:0] req_addr, req_wdata, rsp_rdata, nibble_pin_in, nibble_pin_out, nibble_pin_oe;
  logic [7:0] byte_pin_in, byte_pin_out, byte_pin_oe, bitwise_pin_in, bitwise_pin_out;
  logic [7:0] bitwise_pin_oe, nib_ext, byte_ext, bit_ext, w, d, m, e, rx_got;
  logic [3:0] fixed_in;
  logic [7:4] fixed_out;
  logic t1, go, tx_strobe, rx_ack;
  logic [7:0] modes [4] = '{8'h00, 8'h49, 8'h40, 8'h09};
  logic [7:0] expq [$];
  int bad_count, n_checks, seed, i, k;
  assign fixed_in = {rx_ack, tx_strobe, t1, ~t1};
  assign nibble_pin_in = nibble_pin_out & nibble_pin_oe | nib_ext & ~nibble_pin_oe;
  assign byte_pin_in = byte_pin_out & byte_pin_oe | byte_ext & ~byte_pin_oe;
  assign bitwise_pin_in = bitwise_pin_out & bitwise_pin_oe | bit_ext & ~bitwise_pin_oe;
  pio_top dut (.clk, .reset_n, .extended_register_bank, .req_valid, .req_ready, .req_write,
    .req_addr, .req_wdata, .rsp_valid, .rsp_ready, .rsp_rdata, .nibble_pin_in,
    .nibble_pin_out, .nibble_pin_oe, .byte_pin_in, .byte_pin_out, .byte_pin_oe,
    .bitwise_pin_in, .bitwise_pin_out, .bitwise_pin_oe, .fixed_in, .fixed_out,
    .spi_enable, .spi_data_out, .spi_data_in, .timer_input_line);
  pio_peer #(.SEND(1'b1), .DLY(2)) tx (.clk, .go, .word(w), .data_in(nibble_pin_in),
    .data_out(nib_ext), .got(), .line_out(tx_strobe), .line_in(fixed_out[5]));
  pio_peer #(.SEND(1'b0), .DLY(5)) rx (.clk, .go, .word(w), .data_in(byte_pin_in),
    .data_out(), .got(rx_got), .line_out(rx_ack), .line_in(fixed_out[4]));
  // ====
  // tasks
  task automatic conclude();
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    n_checks++;
    if (g !== x) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 200) begin
      bad_count++;
      $display("Error at %0t: wait ran out", $time);
      conclude();
    end
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] dv);
    @(negedge clk);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = dv;
    #1;
    for (i = 0; i < 200 && !req_ready; i++) begin
      @(negedge clk);
      #1;
    end
    tmo(i);
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    repeat (3) @(negedge clk);
    expq.push_back(x);
    acc(1'b0, a, 8'h00);
  endtask
  // ====
  // clock, stall pattern, answer monitor
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) rsp_ready = ($random(seed) & 3) != 0;
  always @(posedge clk) begin
    if (reset_n && rsp_valid && rsp_ready) begin
      if (expq.size() > 0) chk(rsp_rdata, expq.pop_front());
      else chk(8'h01, 8'h00);
    end
  end
  initial begin
    #1000000;
    tmo(200);
  end
  // ====
  // main sequence
  initial begin
    seed = 1967;
    {reset_n, extended_register_bank, req_valid, req_write, t1, go} = '0;
    {spi_enable, spi_data_out, req_addr, req_wdata, byte_ext, bit_ext} = '0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    rd(NIBBLE_BYTE_MODE_OFS, NIBBLE_BYTE_MODE_RST);
    rd(BITWISE_DIR_OFS, BITWISE_DIR_RST);
    rd(FIXED_FUNC_OFS, READ_ZERO);
    rd(8'h40, READ_ZERO);
    acc(1'b1, FIXED_PORT_OFS, 8'h70);
    rd(FIXED_PORT_OFS, 8'h7d);
    acc(1'b1, FIXED_PORT_OFS, 8'hf0);
    for (k = 0; k < 6; k++) begin
      d = $random(seed);
      w = $random(seed);
      bit_ext = $random(seed);
      t1 = w[0];
      acc(1'b1, FIXED_FUNC_OFS, {7'h0, k[0]});
      acc(1'b1, BITWISE_DIR_OFS, d);
      acc(1'b1, BITWISE_PORT_OFS, w);
      e = k[0] ? ~d & ~w : ~d;
      chk(bitwise_pin_oe, e);
      rd(BITWISE_PORT_OFS, (k[0] ? 8'h00 : w) & e | bit_ext & ~e);
    end
    acc(1'b1, FIXED_FUNC_OFS, 8'h00);
    bit_ext = 8'h01;
    spi_data_out = 1'b1;
    spi_enable = 1'b1;
    repeat (4) @(negedge clk);
    chk({spi_data_in, bitwise_pin_oe[7], bitwise_pin_out[7], bitwise_pin_oe[0], 4'h0}, 8'he0);
    spi_enable = 1'b0;
    for (k = 0; k < 4; k++) begin
      m = modes[k];
      w = $random(seed);
      byte_ext = $random(seed);
      acc(1'b1, NIBBLE_BYTE_MODE_OFS, m);
      acc(1'b1, NIBBLE_PORT_OFS, w);
      acc(1'b1, BYTE_PORT_OFS, ~w);
      e = {{4{m[7:6] == 2'h0}}, {4{m[1:0] == 2'h0}}};
      chk(nibble_pin_oe, e);
      rd(NIBBLE_PORT_OFS, w & e | nib_ext & ~e);
      e = {8{m[4:3] == 2'h0}};
      chk(byte_pin_oe, e);
      rd(BYTE_PORT_OFS, ~w & e | byte_ext & ~e);
    end
    acc(1'b1, NIBBLE_BYTE_MODE_OFS, 8'h49);
    acc(1'b1, FIXED_FUNC_OFS, 8'h04);
    chk({7'h0, fixed_out[5]}, 8'h01);
    w = $random(seed);
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
    for (i = 0; i < 200 && fixed_out[5] !== 1'b0; i++) @(negedge clk);
    tmo(i);
    for (i = 0; i < 200 && !tx_strobe; i++) @(negedge clk);
    tmo(i);
    repeat (4) @(negedge clk);
    chk({7'h0, fixed_out[5]}, 8'h00);
    rd(NIBBLE_PORT_OFS, w);
    for (i = 0; i < 200 && fixed_out[5] !== 1'b1; i++) @(negedge clk);
    tmo(i);
    acc(1'b1, NIBBLE_BYTE_MODE_OFS, 8'h41);
    acc(1'b1, FIXED_FUNC_OFS, 8'h18);
    for (k = 0; k < 3; k++) begin
      w = $random(seed);
      // ack must reach the synchroniser output before the write starts a transfer
      repeat (3) @(negedge clk);
      acc(1'b1, BYTE_PORT_OFS, w);
      for (i = 0; i < 200 && rx_ack; i++) @(negedge clk);
      tmo(i);
      for (i = 0; i < 200 && !rx_ack; i++) @(negedge clk);
      tmo(i);
      chk(rx_got, w);
      chk({7'h0, fixed_out[4]}, 8'h01);
    end
    extended_register_bank = 1'b1;
    rd(NIBBLE_PORT_OFS, READ_ZERO);
    extended_register_bank = 1'b0;
    rd(NIBBLE_PORT_OFS, nib_ext);
    for (i = 0; i < 200 && expq.size() > 0; i++) @(negedge clk);
    tmo(i);
    conclude();
  end
endmodule
